// ==== src/rpmc_pkg.sv ====
// Package of constants and types for the reset and power-mode controller
package rpmc_pkg;
  // Reset cause flag positions
  localparam int CAUSE_W = 6;
  localparam int CAUSE_PIN = 0;
  localparam int CAUSE_POR = 1;
  localparam int CAUSE_BOD = 2;
  localparam int CAUSE_WDT = 3;
  localparam int CAUSE_SW = 4;
  localparam int CAUSE_BRK = 5;
  localparam logic [5:0] CAUSE_NONE = 6'h00;
  localparam logic [5:0] CAUSE_POR_SET = 6'h06;

  // Reset pin modes, high select bit first
  localparam logic [1:0] PIN_GPIO = 2'h0;
  localparam logic [1:0] PIN_RST_IN = 2'h1;
  localparam logic [1:0] PIN_BIDIR = 2'h2;
  localparam logic [1:0] PIN_RST_OUT = 2'h3;

  // Fetch vector
  localparam logic [15:0] FETCH_ZERO = 16'h0000;
  localparam logic [7:0] BOOT_LOW = 8'h00;

  // Wake-up delay in oscillator cycles, plus fixed delay
  localparam int WAKE_XTAL_CYC = 992;
  localparam int WAKE_RC_CYC = 224;
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_FIXED_US = 100;
  localparam int WAKE_FIXED_CYC = (WAKE_FIXED_US * 1000) / CLK_PERIOD_NS;
  localparam int WAKE_CNT_W = 14;

  // Stretched reset pulse on the pin output
  localparam int RST_OUT_CYC = 16;

  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_IDLE = 2'b01,
    PWR_DOWN = 2'b10,
    PWR_TOTAL = 2'b11
  } rpmc_pwr_e;
endpackage

// ==== src/rpmc_wake_timer.sv ====
// Wake-up delay counter holding the core clock off after a stopped-clock state
`timescale 1ns/1ps
module rpmc_wake_timer #(
  parameter int CNT_W = 14
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [CNT_W-1:0] i_count,
  output logic o_busy
);
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  wire count_zero = (count_reg == '0);

  assign count_next = i_start ? i_count : (count_zero ? count_reg : count_reg - 1'b1);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      count_reg <= '0;
      o_busy <= 1'b0;
    end else begin
      count_reg <= count_next;
      o_busy <= (count_next != '0);
    end
  end
endmodule // rpmc_wake_timer

// ==== src/rpmc_ctrl.sv ====
// Reset, brownout and power-mode controller top
`timescale 1ns/1ps
// Notes on behaviour
// - Brownout resets by default; configured otherwise it raises an interrupt instead.
// - Brownout supervision can be disabled; disabled means no reset, no interrupt.
// - Power-on flag is set on power-up and held until software clears it.
// - Idle keeps peripherals running; ends on enabled interrupt or any reset.
// - Power-down stops the oscillator; left only via reset or wake interrupt.
// - Ordinary power-down keeps brownout, watchdog, comparators and system timer running.
// - Power-down stops RC oscillator unless it clocks the system and timer runs.
// - Total power-down also switches off brownout supervision and comparators.
// - Two select bits choose input, reset input, open-drain reset, push-pull output.
// - During power-up the pin is a reset input regardless of selection.
// - Non power-up resets keep the configured pin mode in force.
// - Reset causes: pin, power-on, brownout, watchdog, software, serial break.
// - Each cause has a flag; writing zero to a flag bit clears it.
// - Power-on reset sets power-on and brownout flags, clears all others.
// - Other resets set own flag and keep uncleared earlier flags.
// - First fetch is 0000H or boot vector high byte with low byte 00H.
// - Boot address after serial break, boot status bit set, or forced programming at power-on.
// - Leaving stopped clock holds core clock 992 or 224 cycles plus fixed delay.
module rpmc_ctrl
  import rpmc_pkg::*;
#(
  parameter int WAKE_FIXED = rpmc_pkg::WAKE_FIXED_CYC
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_power_on,
  input wire logic i_brownout,
  input wire logic i_brownout_enable_fuse,
  input wire logic i_brownout_irq_mode,
  input wire logic i_brownout_sw_enable,
  input wire logic i_watchdog_reset,
  input wire logic i_software_reset,
  input wire logic i_break_reset,
  input wire logic i_reset_pin_sel_low,
  input wire logic i_reset_pin_sel_high,
  input wire logic i_shared_reset_pin_in,
  input wire logic i_cause_write,
  input wire logic [rpmc_pkg::CAUSE_W-1:0] i_cause_wdata,
  input wire logic i_boot_status_bit,
  input wire logic i_force_isp,
  input wire logic [7:0] i_boot_vector,
  input wire logic i_idle_req,
  input wire logic i_pd_req,
  input wire logic i_total_pd_req,
  input wire logic i_irq_pending,
  input wire logic i_wake_irq,
  input wire logic i_xtal_source,
  input wire logic i_rc_is_sysclk,
  input wire logic i_rtc_enable,
  input wire logic i_comparator_pd,
  output logic o_core_reset,
  output logic o_brownout_irq,
  output logic [rpmc_pkg::CAUSE_W-1:0] o_reset_cause,
  output logic o_power_on_flag,
  output logic o_brownout_flag,
  output logic o_shared_reset_pin_out,
  output logic o_shared_reset_pin_oe,
  output logic o_shared_reset_pin_pullup,
  output logic [15:0] o_fetch_addr,
  output logic [1:0] o_power_state,
  output logic o_osc_enable,
  output logic o_rc_osc_enable,
  output logic o_brownout_active,
  output logic o_comparator_enable,
  output logic o_peripheral_clk_en,
  output logic o_core_clk_en
);
  import rpmc_pkg::*;

  // ----------------------------------------------------------------
  // Power-up tracking
  // ----------------------------------------------------------------
  logic powerup_reg;
  logic [1:0] pin_mode;
  logic pin_reset_in;
  logic pin_acts_input;

  // Power-up phase lasts while the supply detector holds, then pin mode applies
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      powerup_reg <= 1'b1;
    end else begin
      powerup_reg <= i_power_on;
    end
  end

  assign pin_mode = powerup_reg ? PIN_RST_IN : {i_reset_pin_sel_high, i_reset_pin_sel_low};
  assign pin_acts_input = (pin_mode == PIN_RST_IN) || (pin_mode == PIN_BIDIR);
  // Low on the pin is a reset request; held low past power-on it keeps reset only in reset-input or open-drain mode.
  // Our own open-drain pulse is masked, or it would retrigger itself forever.
  assign pin_reset_in = pin_acts_input && !i_shared_reset_pin_in && !o_shared_reset_pin_oe;

  // ----------------------------------------------------------------
  // Brownout
  // ----------------------------------------------------------------
  logic pwr_total;
  logic bod_live;
  logic bod_reset;
  logic bod_irq;

  assign pwr_total = (o_power_state == PWR_TOTAL);
  assign bod_live = i_brownout_enable_fuse && i_brownout_sw_enable && !pwr_total;
  assign bod_reset = bod_live && i_brownout && !i_brownout_irq_mode;
  assign bod_irq = bod_live && i_brownout && i_brownout_irq_mode;

  // ----------------------------------------------------------------
  // Reset causes and flags
  // ----------------------------------------------------------------
  logic [CAUSE_W-1:0] cause_evt;
  logic [CAUSE_W-1:0] cause_reg;
  logic [CAUSE_W-1:0] cause_next;
  logic [CAUSE_W-1:0] cause_kept;
  logic any_reset;

  assign cause_evt[CAUSE_PIN] = pin_reset_in;
  assign cause_evt[CAUSE_POR] = i_power_on;
  assign cause_evt[CAUSE_BOD] = bod_reset;
  assign cause_evt[CAUSE_WDT] = i_watchdog_reset;
  assign cause_evt[CAUSE_SW] = i_software_reset;
  assign cause_evt[CAUSE_BRK] = i_break_reset;
  assign any_reset = |cause_evt;

  // Software clears by writing zero; a new cause in the same cycle still sets
  assign cause_kept = i_cause_write ? (cause_reg & i_cause_wdata) : cause_reg;
  assign cause_next = i_power_on ? CAUSE_POR_SET : (cause_kept | cause_evt);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cause_reg <= CAUSE_POR_SET;
    end else begin
      cause_reg <= cause_next;
    end
  end

  // ----------------------------------------------------------------
  // Boot vector selection
  // ----------------------------------------------------------------
  logic use_boot;
  logic [15:0] fetch_next;
  logic boot_latch_reg;

  // The break cause is latched per reset so a later clear does not move the vector
  assign use_boot = i_break_reset || i_boot_status_bit || (i_power_on && i_force_isp);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      boot_latch_reg <= 1'b0;
    end else if (any_reset) begin
      boot_latch_reg <= use_boot;
    end
  end

  assign fetch_next = (any_reset ? use_boot : boot_latch_reg) ? {i_boot_vector, BOOT_LOW} : FETCH_ZERO;

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  rpmc_pwr_e state_reg;
  rpmc_pwr_e state_next;
  logic stopped;
  logic wake_start;
  logic wake_busy;
  logic [WAKE_CNT_W-1:0] wake_len;

  assign stopped = (state_reg == PWR_DOWN) || (state_reg == PWR_TOTAL);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PWR_RUN: begin
        if (i_total_pd_req) begin
          state_next = PWR_TOTAL;
        end else if (i_pd_req) begin
          state_next = PWR_DOWN;
        end else if (i_idle_req) begin
          state_next = PWR_IDLE;
        end
      end
      PWR_IDLE: begin
        if (i_irq_pending) begin
          state_next = PWR_RUN;
        end
      end
      PWR_DOWN, PWR_TOTAL: begin
        if (i_wake_irq) begin
          state_next = PWR_RUN;
        end
      end
      default: begin
        state_next = PWR_RUN;
      end
    endcase
    if (any_reset) begin
      state_next = PWR_RUN;
    end
  end

  // Restart the clock-stable delay whenever leaving a stopped-clock state
  assign wake_start = stopped && (state_next == PWR_RUN);
  assign wake_len = WAKE_CNT_W'((i_xtal_source ? WAKE_XTAL_CYC : WAKE_RC_CYC) + WAKE_FIXED);

  rpmc_wake_timer #(
    .CNT_W(WAKE_CNT_W)
  ) u_wake (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_start(wake_start),
    .i_count(wake_len),
    .o_busy(wake_busy)
  );

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg <= PWR_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Reset pin drive, stretched so the far side sees the pulse
  // ----------------------------------------------------------------
  logic [4:0] rst_out_reg;
  logic drive_low;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rst_out_reg <= 5'h00;
    end else if (any_reset) begin
      rst_out_reg <= 5'(RST_OUT_CYC);
    end else if (rst_out_reg != 5'h00) begin
      rst_out_reg <= rst_out_reg - 5'h01;
    end
  end

  assign drive_low = any_reset || (rst_out_reg != 5'h00);

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  logic next_is_stopped;
  assign next_is_stopped = (state_next == PWR_DOWN) || (state_next == PWR_TOTAL);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_core_reset <= 1'b1;
      o_brownout_irq <= 1'b0;
      o_reset_cause <= CAUSE_POR_SET;
      o_power_on_flag <= 1'b1;
      o_brownout_flag <= 1'b1;
      o_shared_reset_pin_out <= 1'b0;
      o_shared_reset_pin_oe <= 1'b0;
      o_shared_reset_pin_pullup <= 1'b1;
      o_fetch_addr <= FETCH_ZERO;
      o_power_state <= PWR_RUN;
      o_osc_enable <= 1'b1;
      o_rc_osc_enable <= 1'b1;
      o_brownout_active <= 1'b0;
      o_comparator_enable <= 1'b0;
      o_peripheral_clk_en <= 1'b1;
      o_core_clk_en <= 1'b0;
    end else begin
      o_core_reset <= any_reset;
      o_brownout_irq <= bod_irq;
      o_reset_cause <= cause_next;
      o_power_on_flag <= cause_next[CAUSE_POR];
      o_brownout_flag <= cause_next[CAUSE_BOD];
      // Push-pull drives both levels; open-drain only pulls low
      o_shared_reset_pin_out <= (pin_mode == PIN_RST_OUT) ? !drive_low : 1'b0;
      o_shared_reset_pin_oe <= (pin_mode == PIN_RST_OUT) || ((pin_mode == PIN_BIDIR) && drive_low);
      o_shared_reset_pin_pullup <= (pin_mode == PIN_RST_IN) || (pin_mode == PIN_BIDIR);
      o_fetch_addr <= fetch_next;
      o_power_state <= state_next;
      o_osc_enable <= !next_is_stopped;
      o_rc_osc_enable <= !next_is_stopped || (i_rc_is_sysclk && i_rtc_enable);
      o_brownout_active <= i_brownout_enable_fuse && i_brownout_sw_enable && (state_next != PWR_TOTAL);
      o_comparator_enable <= !i_comparator_pd && (state_next != PWR_TOTAL);
      o_peripheral_clk_en <= !next_is_stopped;
      o_core_clk_en <= (state_next == PWR_RUN) && !wake_start && !wake_busy && !any_reset;
    end
  end
endmodule // rpmc_ctrl

// ==== sim/rpmc_ctrl_asserts.sv ====
// Concurrent checks on the reset and power-mode controller ports
`timescale 1ns/1ps
module rpmc_ctrl_asserts
  import rpmc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_power_on,
  input wire logic i_watchdog_reset,
  input wire logic i_break_reset,
  input wire logic i_cause_write,
  input wire logic i_reset_pin_sel_high,
  input wire logic i_pd_req,
  input wire logic i_irq_pending,
  input wire logic [rpmc_pkg::CAUSE_W-1:0] o_reset_cause,
  input wire logic o_power_on_flag,
  input wire logic o_brownout_flag,
  input wire logic o_core_reset,
  input wire logic o_shared_reset_pin_oe,
  input wire logic [15:0] o_fetch_addr,
  input wire logic [1:0] o_power_state,
  input wire logic o_osc_enable,
  input wire logic o_brownout_active,
  input wire logic o_comparator_enable
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  por_flags_a: assert property (i_power_on |=> o_reset_cause == CAUSE_POR_SET)
    else $error("power-on did not leave only the power-on and brownout flags");
  wdt_flag_a: assert property (i_watchdog_reset && !i_power_on |=> o_reset_cause[CAUSE_WDT] && o_core_reset)
    else $error("watchdog request gave no flag or no core reset");
  brk_flag_a: assert property (i_break_reset && !i_power_on |=> o_reset_cause[CAUSE_BRK])
    else $error("break request gave no flag");
  flags_keep_a: assert property (!i_cause_write && !i_power_on |=> ($past(o_reset_cause) & ~o_reset_cause) == CAUSE_NONE)
    else $error("a cause flag dropped without a write");
  flag_copy_a: assert property (o_power_on_flag == o_reset_cause[CAUSE_POR] && o_brownout_flag == o_reset_cause[CAUSE_BOD])
    else $error("flag outputs differ from cause bits");
  fetch_low_a: assert property (o_fetch_addr[7:0] == BOOT_LOW)
    else $error("fetch address low byte not zero");
  pin_input_a: assert property (!i_reset_pin_sel_high |=> !o_shared_reset_pin_oe)
    else $error("pin driven in an input mode");
  total_off_a: assert property (o_power_state == PWR_TOTAL && $past(o_power_state) == PWR_TOTAL
    |-> !o_brownout_active && !o_comparator_enable)
    else $error("brownout or comparators on in total power-down");
  pd_enter_a: assert property (i_pd_req && o_power_state == PWR_RUN && !o_core_reset && !i_power_on && !i_watchdog_reset
    |=> o_power_state == PWR_DOWN && !o_osc_enable)
    else $error("power-down request not taken");
  idle_exit_a: assert property (o_power_state == PWR_IDLE && i_irq_pending |=> o_power_state == PWR_RUN)
    else $error("idle not left on interrupt");
  cover property (i_watchdog_reset ##1 o_core_reset);
  cover property (o_power_state == PWR_DOWN);
  cover property (o_power_state == PWR_TOTAL);
endmodule // rpmc_ctrl_asserts

bind rpmc_ctrl rpmc_ctrl_asserts u_asserts (.*);

// ==== sim/rpmc_reset_circuit.sv ====
// Behavioural model of the board circuit on the shared reset pin
`timescale 1ns/1ps
module rpmc_reset_circuit (
  input wire logic i_clock,
  input wire logic i_pull_low,
  input wire logic i_ext_pullup,
  input wire logic i_dev_out,
  input wire logic i_dev_oe,
  input wire logic i_dev_pullup,
  output logic o_pin
);
  logic float_reg = 1'b0;
  // A pin nobody holds wanders, so a missing pull-up shows up as noise
  always_ff @(posedge i_clock) begin
    float_reg <= ~float_reg;
  end
  // Held low only when commanded, never by default through power-on
  assign o_pin = i_pull_low ? 1'b0 : i_dev_oe ? i_dev_out : (i_ext_pullup | i_dev_pullup) ? 1'b1 : float_reg;
endmodule // rpmc_reset_circuit

// ==== sim/tb_rpmc_ctrl.sv ====
// Self-checking testbench for the reset and power-mode controller
`timescale 1ns/1ps
module tb_rpmc_ctrl;
  import rpmc_pkg::*;
  logic i_clock = 1'b0, i_rst = 1'b1, i_power_on = 1'b0, i_brownout = 1'b0, i_brownout_enable_fuse = 1'b1;
  logic i_brownout_irq_mode = 1'b0, i_brownout_sw_enable = 1'b1, i_watchdog_reset = 1'b0, i_software_reset = 1'b0;
  logic i_break_reset = 1'b0, i_reset_pin_sel_low = 1'b1, i_reset_pin_sel_high = 1'b0, i_cause_write = 1'b0;
  logic [5:0] i_cause_wdata = 6'h3F;
  logic i_boot_status_bit = 1'b0, i_force_isp = 1'b0, i_idle_req = 1'b0, i_pd_req = 1'b0, i_total_pd_req = 1'b0;
  logic i_irq_pending = 1'b0, i_wake_irq = 1'b0, i_xtal_source = 1'b1, i_rc_is_sysclk = 1'b0, i_rtc_enable = 1'b0;
  logic i_comparator_pd = 1'b0, i_shared_reset_pin_in, pull_low = 1'b0;
  logic [7:0] i_boot_vector = 8'h00;
  logic o_core_reset, o_brownout_irq, o_power_on_flag, o_brownout_flag, o_shared_reset_pin_out, o_shared_reset_pin_oe;
  logic o_shared_reset_pin_pullup, o_osc_enable, o_rc_osc_enable, o_brownout_active, o_comparator_enable;
  logic o_peripheral_clk_en, o_core_clk_en;
  logic [5:0] o_reset_cause, exp_cause;
  logic [15:0] o_fetch_addr;
  logic [1:0] o_power_state;
  logic [31:0] seed = 32'd33649;
  int n_mismatch = 0, comparisons = 0, n;

  rpmc_ctrl #(.WAKE_FIXED(4)) dut (.*);
  rpmc_reset_circuit u_board (.i_clock(i_clock), .i_pull_low(pull_low), .i_ext_pullup(1'b1),
    .i_dev_out(o_shared_reset_pin_out), .i_dev_oe(o_shared_reset_pin_oe),
    .i_dev_pullup(o_shared_reset_pin_pullup), .o_pin(i_shared_reset_pin_in));

  always #5 i_clock = ~i_clock;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clock);
  endtask
  // Callers sample at the falling edge, where registered outputs have settled
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_cause(input logic [5:0] m);
    cyc(1);
    i_cause_write <= 1'b1;
    i_cause_wdata <= m;
    cyc(1);
    i_cause_write <= 1'b0;
    exp_cause = exp_cause & m;
  endtask
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clock);
    n_mismatch++;
    stop_test();
  end

  initial begin
    i_boot_vector = 8'(rnd());
    exp_cause = CAUSE_POR_SET;
    cyc(8);
    i_rst <= 1'b0;
    @(negedge i_clock);
    chk(o_reset_cause, exp_cause);
    chk(o_fetch_addr, FETCH_ZERO);
    for (int k = 0; k < 3; k++) begin
      wr_cause(6'(rnd()));
      @(negedge i_clock);
      chk(o_reset_cause, exp_cause);
    end
    wr_cause(6'h00);
    // Break first so the next plain reset must fall back to address zero
    for (int k = 5; k >= 3; k--) begin
      cyc(1);
      {i_break_reset, i_software_reset, i_watchdog_reset} <= 3'b100 >> (5 - k);
      cyc(1);
      {i_break_reset, i_software_reset, i_watchdog_reset} <= 3'b000;
      exp_cause[k] = 1'b1;
      @(negedge i_clock);
      chk(o_reset_cause, exp_cause);
      chk(o_core_reset, 1'b1);
      chk(o_fetch_addr, k == 5 ? {i_boot_vector, 8'h00} : FETCH_ZERO);
    end
    cyc(1);
    i_boot_status_bit <= 1'b1;
    i_software_reset <= 1'b1;
    cyc(1);
    i_software_reset <= 1'b0;
    i_boot_status_bit <= 1'b0;
    @(negedge i_clock);
    chk(o_fetch_addr, {i_boot_vector, 8'h00});
    for (int j = 0; j < 3; j++) begin
      wr_cause(6'h00);
      i_brownout_irq_mode <= (j == 1);
      i_brownout_sw_enable <= (j != 2);
      cyc(1);
      i_brownout <= 1'b1;
      cyc(1);
      @(negedge i_clock);
      chk(o_reset_cause, {3'b000, j == 0, 2'b00});
      chk(o_brownout_irq, j == 1);
      cyc(1);
      i_brownout <= 1'b0;
    end
    i_brownout_sw_enable <= 1'b1;
    i_brownout_irq_mode <= 1'b0;
    for (int m = 1; m >= 0; m--) begin
      wr_cause(6'h00);
      i_reset_pin_sel_low <= m[0];
      cyc(2);
      pull_low <= 1'b1;
      cyc(2);
      pull_low <= 1'b0;
      @(negedge i_clock);
      chk(o_reset_cause, {5'h00, m[0]});
    end
    for (int m = 2; m < 4; m++) begin
      cyc(1);
      {i_reset_pin_sel_high, i_reset_pin_sel_low} <= m[1:0];
      cyc(2);
      i_watchdog_reset <= 1'b1;
      cyc(1);
      i_watchdog_reset <= 1'b0;
      cyc(1);
      @(negedge i_clock);
      chk({o_shared_reset_pin_oe, o_shared_reset_pin_out}, 16'h0002);
      cyc(40);
    end
    {i_reset_pin_sel_high, i_reset_pin_sel_low} <= 2'b00;
    pull_low <= 1'b1;
    i_power_on <= 1'b1;
    cyc(3);
    exp_cause = CAUSE_POR_SET;
    @(negedge i_clock);
    chk(o_core_reset, 1'b1);
    chk(o_reset_cause, exp_cause);
    cyc(1);
    i_power_on <= 1'b0;
    cyc(3);
    wr_cause(6'h00);
    cyc(3);
    @(negedge i_clock);
    chk(o_reset_cause, exp_cause);
    cyc(1);
    pull_low <= 1'b0;
    {i_reset_pin_sel_high, i_reset_pin_sel_low} <= 2'b01;
    cyc(40);
    i_idle_req <= 1'b1;
    cyc(1);
    i_idle_req <= 1'b0;
    @(negedge i_clock);
    chk({o_power_state, o_peripheral_clk_en}, {PWR_IDLE, 1'b1});
    cyc(1);
    i_irq_pending <= 1'b1;
    cyc(1);
    i_irq_pending <= 1'b0;
    @(negedge i_clock);
    chk(o_power_state, PWR_RUN);
    for (int t = 0; t < 2; t++) begin
      cyc(1);
      {i_rc_is_sysclk, i_rtc_enable} <= {t[0], t[0]};
      i_pd_req <= !t[0];
      i_total_pd_req <= t[0];
      cyc(1);
      {i_pd_req, i_total_pd_req} <= 2'b00;
      @(negedge i_clock);
      chk({o_power_state, o_osc_enable, o_rc_osc_enable}, {t[0] ? PWR_TOTAL : PWR_DOWN, 1'b0, t[0]});
      chk({o_brownout_active, o_comparator_enable}, {!t[0], !t[0]});
      cyc(1);
      i_xtal_source <= !t[0];
      i_wake_irq <= 1'b1;
      cyc(1);
      i_wake_irq <= 1'b0;
      @(negedge i_clock);
      chk(o_power_state, PWR_RUN);
      n = 0;
      while (o_core_clk_en !== 1'b1 && n < 2000) begin
        @(negedge i_clock);
        n++;
      end
      chk(n >= (t[0] ? WAKE_RC_CYC : WAKE_XTAL_CYC) && n <= (t[0] ? WAKE_RC_CYC : WAKE_XTAL_CYC) + 8, 1'b1);
    end
    stop_test();
  end
endmodule // tb_rpmc_ctrl
